// *** inc/rac_pkg.sv ***
// shared constants and types for the register access and calibration decoder
package rac_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int RAC_DATA_W = 24;
  localparam int RAC_IDX_W = 5;
  localparam int RAC_PAGE_W = 6;
  localparam int RAC_SLOT_W = 6;
  localparam int RAC_SLOTS = 40;
  localparam int RAC_BYTE_W = 8;
  localparam logic [1:0] RAC_LAST_DATA_BYTE = 2'h2;

  // ----------------------------------------------------------------
  // page 0 register indices
  // ----------------------------------------------------------------
  localparam logic [4:0] RAC_P0_CONFIGURATION = 5'h00;
  localparam logic [4:0] RAC_P0_CURRENT_DC_OFFSET = 5'h01;
  localparam logic [4:0] RAC_P0_CURRENT_GAIN = 5'h02;
  localparam logic [4:0] RAC_P0_VOLTAGE_DC_OFFSET = 5'h03;
  localparam logic [4:0] RAC_P0_VOLTAGE_GAIN = 5'h04;
  localparam logic [4:0] RAC_P0_SAMPLES_PER_CYCLE = 5'h05;
  localparam logic [4:0] RAC_P0_ENERGY_PULSE_RATE = 5'h06;
  localparam logic [4:0] RAC_P0_INST_CURRENT = 5'h07;
  localparam logic [4:0] RAC_P0_INST_VOLTAGE = 5'h08;
  localparam logic [4:0] RAC_P0_INST_POWER = 5'h09;
  localparam logic [4:0] RAC_P0_ACTIVE_POWER = 5'h0A;
  localparam logic [4:0] RAC_P0_RMS_CURRENT = 5'h0B;
  localparam logic [4:0] RAC_P0_RMS_VOLTAGE = 5'h0C;
  localparam logic [4:0] RAC_P0_LINE_FREQ_RATIO = 5'h0D;
  localparam logic [4:0] RAC_P0_POWER_OFFSET = 5'h0E;
  localparam logic [4:0] RAC_P0_EVENT_FLAGS = 5'h0F;
  localparam logic [4:0] RAC_P0_CURRENT_AC_OFFSET = 5'h10;
  localparam logic [4:0] RAC_P0_VOLTAGE_AC_OFFSET = 5'h11;
  localparam logic [4:0] RAC_P0_OPERATION_MODE = 5'h12;
  localparam logic [4:0] RAC_P0_TEMPERATURE = 5'h13;
  localparam logic [4:0] RAC_P0_AVG_REACTIVE_POWER = 5'h14;
  localparam logic [4:0] RAC_P0_INST_REACTIVE_POWER = 5'h15;
  localparam logic [4:0] RAC_P0_PEAK_CURRENT = 5'h16;
  localparam logic [4:0] RAC_P0_PEAK_VOLTAGE = 5'h17;
  localparam logic [4:0] RAC_P0_TRIANGLE_REACTIVE_POWER = 5'h18;
  localparam logic [4:0] RAC_P0_POWER_FACTOR = 5'h19;
  localparam logic [4:0] RAC_P0_INTERRUPT_MASK = 5'h1A;
  localparam logic [4:0] RAC_P0_APPARENT_POWER = 5'h1B;
  localparam logic [4:0] RAC_P0_CONTROL = 5'h1C;
  localparam logic [4:0] RAC_P0_HARMONIC_ACTIVE_POWER = 5'h1D;
  localparam logic [4:0] RAC_P0_FUNDAMENTAL_ACTIVE_POWER = 5'h1E;
  localparam logic [4:0] RAC_P0_FUND_REACTIVE_OR_PAGE_SELECT = 5'h1F;

  // ----------------------------------------------------------------
  // page 1 and page 3 register indices
  // ----------------------------------------------------------------
  localparam logic [4:0] RAC_P1_PULSE_OUTPUT_WIDTH = 5'h00;
  localparam logic [4:0] RAC_P1_TEMP_SENSOR_OFFSET = 5'h03;
  localparam logic [4:0] RAC_P3_VOLTAGE_SAG_INTERVAL = 5'h06;
  localparam logic [4:0] RAC_P3_VOLTAGE_SAG_THRESHOLD = 5'h07;
  localparam logic [4:0] RAC_P3_CURRENT_FAULT_INTERVAL = 5'h0A;
  localparam logic [4:0] RAC_P3_CURRENT_FAULT_THRESHOLD = 5'h0B;
  localparam logic [5:0] RAC_PAGE_0 = 6'h00;
  localparam logic [5:0] RAC_PAGE_1 = 6'h01;
  localparam logic [5:0] RAC_PAGE_3 = 6'h03;
  // storage slot bases for page 1 and page 3 registers
  localparam logic [5:0] RAC_SLOT_P1 = 6'h20;
  localparam logic [5:0] RAC_SLOT_P3 = 6'h24;

  // page 0 addresses that hold software-written values (bit per index)
  localparam logic [31:0] RAC_P0_WRITABLE = 32'h140F607F;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [23:0] RAC_CONFIGURATION_RST = 24'h000001;
  localparam logic [23:0] RAC_GAIN_RST = 24'h400000;
  localparam logic [23:0] RAC_SAMPLES_PER_CYCLE_RST = 24'h000FA0;
  localparam logic [23:0] RAC_ENERGY_PULSE_RATE_RST = 24'h800000;

  // ----------------------------------------------------------------
  // command encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] RAC_CMD_CAL_TOP = 3'h6;
  localparam logic [1:0] RAC_CAL_OFFSET = 2'h1;
  localparam logic [1:0] RAC_CAL_GAIN = 2'h2;
  localparam logic [1:0] RAC_CAL_NONE = 2'h0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    RAC_PH_CMD = 1'b0,
    RAC_PH_WDATA = 1'b1
  } rac_phase_type;

  typedef struct packed {
    logic [1:0] channel;  // 01 current, 10 voltage, 11 both
    logic ac;             // 1 ac, 0 dc
    logic [1:0] kind;     // 01 offset, 10 gain
  } rac_cal_type;

  typedef struct packed {
    logic stb;
    logic [RAC_PAGE_W-1:0] page;
    logic [RAC_IDX_W-1:0] index;
    logic [RAC_DATA_W-1:0] data;
  } rac_wr_type;

endpackage

// *** design/rac_shift_in.sv ***
// serial bit collector that assembles msb-first words on clock rising edges
`timescale 1ns/1ps
module rac_shift_in
  import rac_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clear,
  input wire logic shift_en,
  input wire logic din,
  output logic [W-1:0] word,
  output logic done
);

  typedef struct packed {
    logic [W-1:0] sh;
    logic [$clog2(W)-1:0] cnt;
    logic [W-1:0] word;
    logic done;
  } rac_shin_type;

  rac_shin_type s_reg;
  rac_shin_type s_next;

  // ----------------------------------------------------------------
  // shift msb first, flag a full word for one cycle
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    if (rst || clear) begin
      s_next.sh = '0;
      s_next.cnt = '0;
    end else if (shift_en) begin
      s_next.sh = {s_reg.sh[W-2:0], din};
      s_next.cnt = s_reg.cnt + 1'b1;
      if (s_reg.cnt == ($clog2(W))'(W - 1)) begin
        s_next.word = {s_reg.sh[W-2:0], din};
        s_next.done = 1'b1;
        s_next.cnt = '0;
      end
    end
    if (rst) begin
      s_next.word = '0;
      s_next.done = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    s_reg <= s_next;
  end

  assign word = s_reg.word;
  assign done = s_reg.done;

endmodule

// *** design/rac_decoder.sv ***
// serial command decoder for register access and calibration commands
// Summary of operation
// (R1) msb 0 is register access; bit6 1 writes
// (R2) bits 5..1 give index, bit0 is zero
// (R3) read loads addressed register, shifts out sdo
// (R4) write data lands after 24th data clock
// (R5) page 0 indices 0..6 are setup registers
// (R6) page 0 indices 7..15 results, ratio, flags
// (R7) page 0 indices 16..23 offsets, mode, results
// (R8) page 0 indices 24..30 results, mask, control
// (R9) index 31 reads result, writes page select
// (R10) page 1 indices 0..3 pulse, load, temperature
// (R11) page 3 indices 6,7,10,11 sag and fault
// (R12) host never writes undefined addresses
// (R13) top bits 110 mark a calibration command
// (R14) calibration field bits 4..3 pick channel
// (R15) bit2 picks ac, bits 1..0 offset/gain
// (R16) host sends only twelve calibration codes
// (R17) host applies reference signals before calibrating
// (R18) every register takes its default on reset
// (R19) host writes reserved bits as zero
// (R20) write command takes exactly three data bytes
// (R21) all bytes travel most significant bit first
// (R22) page defaults zero, changes only via index 31
// (R23) unknown command bytes change nothing
`timescale 1ns/1ps
module rac_decoder
  import rac_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic [RAC_DATA_W-1:0] result_data,
  input wire logic [RAC_DATA_W-1:0] event_set,
  output logic sdo,
  output logic [RAC_IDX_W-1:0] result_index,
  output logic [RAC_PAGE_W-1:0] page_sel,
  output logic [RAC_DATA_W-1:0] event_flags,
  output logic [RAC_DATA_W-1:0] configuration,
  output logic [RAC_DATA_W-1:0] control,
  output rac_wr_type wr_out,
  output logic cal_start,
  output rac_cal_type cal_out
);

  typedef struct packed {
    logic [RAC_SLOTS-1:0][RAC_DATA_W-1:0] regfile;
    logic [RAC_DATA_W-1:0] flags;
    logic [RAC_PAGE_W-1:0] page;
    rac_phase_type phase;
    logic [1:0] dcount;
    logic [15:0] wbuf;
    logic [RAC_IDX_W-1:0] wr_index;
    logic [RAC_IDX_W-1:0] rd_index;
    logic rd_pending;
    logic [RAC_DATA_W-1:0] tx;
    logic sdo;
    logic sclk_prev;
    rac_wr_type wr;
    logic cal_start;
    rac_cal_type cal;
  } rac_core_type;

  rac_core_type s_reg;
  rac_core_type s_next;
  logic [RAC_BYTE_W-1:0] rx_byte;
  logic rx_valid;
  logic sclk_rise;
  logic sclk_fall;

  // ----------------------------------------------------------------
  // edge detect on the serial clock
  // ----------------------------------------------------------------
  // sclk is taken as synchronous to mclk; it must stay high and low
  // for at least three mclk periods so a read can load before the fall
  assign sclk_rise = sclk && !s_reg.sclk_prev;
  assign sclk_fall = !sclk && s_reg.sclk_prev;

  rac_shift_in #(
    .W(RAC_BYTE_W)
  ) u_rx (
    .mclk(mclk),
    .rst(rst),
    .clear(cs_n),
    .shift_en(sclk_rise && !cs_n),
    .din(sdi),
    .word(rx_byte),
    .done(rx_valid)
  );

  // ----------------------------------------------------------------
  // address resolution: page and index to a storage slot
  // ----------------------------------------------------------------
  function automatic logic [RAC_SLOT_W:0] slot_of(
    input logic [RAC_PAGE_W-1:0] page,
    input logic [RAC_IDX_W-1:0] index
  );
    logic [RAC_SLOT_W:0] r;
    r = '0;
    if (page == RAC_PAGE_0) begin
      r = {1'b1, 1'b0, index};                                   // R5 R6 R7 R8
    end else if (page == RAC_PAGE_1) begin
      if (index <= RAC_P1_TEMP_SENSOR_OFFSET) begin
        r = {1'b1, RAC_SLOT_P1 | {4'h0, index[1:0]}};            // R10
      end
    end else if (page == RAC_PAGE_3) begin
      case (index)
        RAC_P3_VOLTAGE_SAG_INTERVAL: r = {1'b1, RAC_SLOT_P3};    // R11
        RAC_P3_VOLTAGE_SAG_THRESHOLD: r = {1'b1, RAC_SLOT_P3 + 6'h01};
        RAC_P3_CURRENT_FAULT_INTERVAL: r = {1'b1, RAC_SLOT_P3 + 6'h02};
        RAC_P3_CURRENT_FAULT_THRESHOLD: r = {1'b1, RAC_SLOT_P3 + 6'h03};
        default: r = '0;
      endcase
    end
    return r;
  endfunction

  // true when the page 0 index holds a software value, not a result
  function automatic logic p0_stored(input logic [RAC_IDX_W-1:0] index);
    return RAC_P0_WRITABLE[index];
  endfunction

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [RAC_SLOT_W:0] slot;
    logic [RAC_DATA_W-1:0] wdata;
    logic [RAC_DATA_W-1:0] clr;
    logic [RAC_DATA_W-1:0] rdata;
    slot = '0;
    wdata = '0;
    clr = '0;
    rdata = '0;
    s_next = s_reg;
    s_next.sclk_prev = sclk;
    s_next.wr.stb = 1'b0;
    s_next.cal_start = 1'b0;

    // framing restarts whenever the port is deselected
    if (cs_n) begin
      s_next.phase = RAC_PH_CMD;
      s_next.dcount = '0;
    end else if (rx_valid) begin
      case (s_reg.phase)
        RAC_PH_CMD: begin
          if (!rx_byte[7] && !rx_byte[0]) begin                   // R1 R2
            if (rx_byte[6]) begin
              s_next.phase = RAC_PH_WDATA;                         // R20
              s_next.dcount = '0;
              s_next.wr_index = rx_byte[5:1];                      // R2
            end else begin
              // a new read simply replaces one still shifting out
              s_next.rd_index = rx_byte[5:1];                      // R3
              s_next.rd_pending = 1'b1;
            end
          end else if (rx_byte[7:5] == RAC_CMD_CAL_TOP &&
                       rx_byte[4:3] != 2'h0 &&
                       rx_byte[1:0] != RAC_CAL_NONE &&
                       rx_byte[1:0] != 2'h3) begin                 // R13
            s_next.cal_start = 1'b1;
            s_next.cal.channel = rx_byte[4:3];                     // R14
            s_next.cal.ac = rx_byte[2];                            // R15
            s_next.cal.kind = rx_byte[1:0];                        // R15
          end
          // anything else is not ours and leaves all state alone R23
        end
        RAC_PH_WDATA: begin
          s_next.wbuf = {s_reg.wbuf[7:0], rx_byte};                // R21
          s_next.dcount = s_reg.dcount + 2'h1;
          if (s_reg.dcount == RAC_LAST_DATA_BYTE) begin            // R4 R20
            wdata = {s_reg.wbuf, rx_byte};
            s_next.phase = RAC_PH_CMD;
            s_next.dcount = '0;
            s_next.wr.stb = 1'b1;
            s_next.wr.page = s_reg.page;
            s_next.wr.index = s_reg.wr_index;
            s_next.wr.data = wdata;
            slot = slot_of(s_reg.page, s_reg.wr_index);
            if (s_reg.wr_index == RAC_P0_FUND_REACTIVE_OR_PAGE_SELECT) begin
              s_next.page = wdata[RAC_PAGE_W-1:0];                 // R9 R22
            end else if (s_reg.page == RAC_PAGE_0 &&
                         s_reg.wr_index == RAC_P0_EVENT_FLAGS) begin
              clr = wdata;
            end else if (slot[RAC_SLOT_W] &&
                         (s_reg.page != RAC_PAGE_0 ||
                          p0_stored(s_reg.wr_index))) begin
              s_next.regfile[slot[RAC_SLOT_W-1:0]] = wdata;        // R4
            end
          end
        end
        default: begin
          s_next.phase = RAC_PH_CMD;
        end
      endcase
    end

    // flags: a set in the clearing cycle survives the clear
    s_next.flags = (s_reg.flags & ~clr) | event_set;

    // load the transmit buffer one cycle after a read is decoded
    if (s_reg.rd_pending) begin
      slot = slot_of(s_reg.page, s_reg.rd_index);
      if (s_reg.page == RAC_PAGE_0 && s_reg.rd_index == RAC_P0_EVENT_FLAGS) begin
        rdata = s_reg.flags;
      end else if (s_reg.page == RAC_PAGE_0 && !p0_stored(s_reg.rd_index)) begin
        rdata = result_data;                                       // R9
      end else if (s_reg.page == RAC_PAGE_0 &&
                   s_reg.rd_index == RAC_P0_FUND_REACTIVE_OR_PAGE_SELECT) begin
        rdata = result_data;
      end else if (slot[RAC_SLOT_W]) begin
        rdata = s_reg.regfile[slot[RAC_SLOT_W-1:0]];
      end
      s_next.tx = rdata;                                           // R3
      s_next.rd_pending = 1'b0;
    end else if (sclk_fall && !cs_n) begin
      s_next.sdo = s_reg.tx[RAC_DATA_W-1];                         // R3 R21
      s_next.tx = {s_reg.tx[RAC_DATA_W-2:0], 1'b0};
    end

    // synchronous reset: documented defaults, page 0
    if (rst) begin
      s_next = '0;                                                 // R18
      s_next.phase = RAC_PH_CMD;
      s_next.regfile[RAC_P0_CONFIGURATION] = RAC_CONFIGURATION_RST;
      s_next.regfile[RAC_P0_CURRENT_GAIN] = RAC_GAIN_RST;
      s_next.regfile[RAC_P0_VOLTAGE_GAIN] = RAC_GAIN_RST;
      s_next.regfile[RAC_P0_SAMPLES_PER_CYCLE] = RAC_SAMPLES_PER_CYCLE_RST;
      s_next.regfile[RAC_P0_ENERGY_PULSE_RATE] = RAC_ENERGY_PULSE_RATE_RST;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    s_reg <= s_next;
  end

  // outputs straight from the state flops
  assign sdo = s_reg.sdo;
  assign result_index = s_reg.rd_index;
  assign page_sel = s_reg.page;
  assign event_flags = s_reg.flags;
  assign configuration = s_reg.regfile[RAC_P0_CONFIGURATION];
  assign control = s_reg.regfile[RAC_P0_CONTROL];
  assign wr_out = s_reg.wr;
  assign cal_start = s_reg.cal_start;
  assign cal_out = s_reg.cal;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_cal_decode: assert property (@(posedge mclk) disable iff (rst) // R13
    s_reg.cal_start |-> $past(rx_valid) &&
      $past(rx_byte[7:5]) == RAC_CMD_CAL_TOP)
    else $error("calibration start without a calibration byte");

  chk_cal_channel: assert property (@(posedge mclk) disable iff (rst) // R14
    s_reg.cal_start |-> s_reg.cal.channel == $past(rx_byte[4:3]) &&
      s_reg.cal.channel != 2'h0)
    else $error("calibration channel wrong");

  chk_cal_kind: assert property (@(posedge mclk) disable iff (rst) // R15
    s_reg.cal_start |-> s_reg.cal.ac == $past(rx_byte[2]) &&
      (s_reg.cal.kind == RAC_CAL_OFFSET || s_reg.cal.kind == RAC_CAL_GAIN))
    else $error("calibration ac or kind wrong");

  chk_write_commit: assert property (@(posedge mclk) disable iff (rst) // R4
    s_reg.wr.stb |-> $past(rx_valid) && $past(s_reg.phase) == RAC_PH_WDATA
      && $past(s_reg.dcount) == RAC_LAST_DATA_BYTE)
    else $error("register write before third data byte");

  chk_page_write: assert property (@(posedge mclk) disable iff (rst) // R22
    $changed(s_reg.page) |-> s_reg.wr.stb &&
      s_reg.wr.index == RAC_P0_FUND_REACTIVE_OR_PAGE_SELECT)
    else $error("page changed without page register write");

  chk_read_load: assert property (@(posedge mclk) disable iff (rst) // R3
    (rx_valid && !cs_n && s_reg.phase == RAC_PH_CMD && rx_byte[7:6] == 2'h0
      && !rx_byte[0]) |=> s_reg.rd_pending ##1 !s_reg.rd_pending)
    else $error("read command did not load transmit buffer");

  chk_sdo_shift: assert property (@(posedge mclk) disable iff (rst) // R21
    (sclk_fall && !cs_n && !s_reg.rd_pending) |=>
      s_reg.sdo == $past(s_reg.tx[RAC_DATA_W-1]))
    else $error("serial output not msb first");

  chk_bad_ignored: assert property (@(posedge mclk) disable iff (rst) // R23
    (rx_valid && !cs_n && s_reg.phase == RAC_PH_CMD && rx_byte[7] &&
      rx_byte[7:5] != RAC_CMD_CAL_TOP) |=>
      !s_reg.cal_start && s_reg.phase == RAC_PH_CMD && $stable(s_reg.page))
    else $error("unknown command changed state");

  chk_reset_defaults: assert property (@(posedge mclk) disable iff (rst) // R18
    $past(rst) |-> s_reg.page == RAC_PAGE_0 &&
      s_reg.regfile[RAC_P0_CURRENT_GAIN] == RAC_GAIN_RST &&
      s_reg.regfile[RAC_P0_CONFIGURATION] == RAC_CONFIGURATION_RST)
    else $error("defaults not restored by reset");

  chk_write_enter: assert property (@(posedge mclk) disable iff (rst) // R1
    (rx_valid && !cs_n && s_reg.phase == RAC_PH_CMD && rx_byte[7:6] == 2'h1
      && !rx_byte[0]) |=> s_reg.phase == RAC_PH_WDATA &&
      s_reg.wr_index == $past(rx_byte[5:1]))
    else $error("write command did not open the data phase");

  chk_read_index: assert property (@(posedge mclk) disable iff (rst) // R2
    (rx_valid && !cs_n && s_reg.phase == RAC_PH_CMD && rx_byte[7:6] == 2'h0
      && !rx_byte[0]) |=> s_reg.rd_index == $past(rx_byte[5:1]))
    else $error("read index not taken from bits 5 to 1");

  chk_page_value: assert property (@(posedge mclk) disable iff (rst) // R9
    s_reg.wr.stb && s_reg.wr.index == RAC_P0_FUND_REACTIVE_OR_PAGE_SELECT
      |-> s_reg.page == s_reg.wr.data[RAC_PAGE_W-1:0])
    else $error("page register write did not set the page");

  chk_flag_sticky: assert property (@(posedge mclk) disable iff (rst) // R6
    event_set != '0 |=>
      (s_reg.flags & $past(event_set)) == $past(event_set))
    else $error("event flag not set by its event");

  chk_p0_store: assert property (@(posedge mclk) disable iff (rst) // R5 R7 R8
    s_reg.wr.stb && s_reg.wr.page == RAC_PAGE_0 &&
      RAC_P0_WRITABLE[s_reg.wr.index]
      |-> s_reg.regfile[s_reg.wr.index] == s_reg.wr.data)
    else $error("page 0 write did not reach its register");

  chk_p1_store: assert property (@(posedge mclk) disable iff (rst) // R10
    s_reg.wr.stb && s_reg.wr.page == RAC_PAGE_1 &&
      s_reg.wr.index <= RAC_P1_TEMP_SENSOR_OFFSET |->
      s_reg.regfile[RAC_SLOT_P1 | {4'h0, s_reg.wr.index[1:0]}] ==
      s_reg.wr.data)
    else $error("page 1 write did not reach its register");

  chk_p3_store: assert property (@(posedge mclk) disable iff (rst) // R11
    s_reg.wr.stb && s_reg.wr.page == RAC_PAGE_3 &&
      s_reg.wr.index == RAC_P3_VOLTAGE_SAG_THRESHOLD |->
      s_reg.regfile[RAC_SLOT_P3 + 6'h01] == s_reg.wr.data)
    else $error("page 3 write did not reach its register");

  chk_data_done: assert property (@(posedge mclk) disable iff (rst) // R20
    s_reg.wr.stb |-> s_reg.phase == RAC_PH_CMD && s_reg.dcount == 2'h0)
    else $error("data phase still open after third data byte");

endmodule

// *** bench/rac_host_model.sv ***
// host model that drives framed command traffic on the serial port
`timescale 1ns/1ps
module rac_host_model (
  input wire logic mclk,
  input wire logic sdo,
  output logic cs_n,
  output logic sclk,
  output logic sdi
);
  // ----------------------------------------------------------------
  // idle line behaviour
  // ----------------------------------------------------------------
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end

  // sdi toggles while deselected so stale bits never look valid
  always @(posedge mclk) begin
    if (cs_n) begin
      sdi <= ~sdi;
    end
  end

  // ----------------------------------------------------------------
  // frame transfer
  // ----------------------------------------------------------------
  // command byte plus exactly three bytes; sclk high and low 3 mclk
  // each, so the tx load never lands on the edge of a falling sclk
  task automatic frame(input logic [31:0] tx, output logic [31:0] rx);
    @(posedge mclk);
    cs_n <= 1'b0;
    repeat (2) @(posedge mclk);
    for (int i = 31; i >= 0; i--) begin
      @(posedge mclk);
      sclk <= 1'b0;
      sdi <= tx[i];
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      rx[i] = sdo;
      @(posedge mclk);
      sclk <= 1'b1;
      repeat (2) @(posedge mclk);
    end
    @(posedge mclk);
    sclk <= 1'b0;
    repeat (3) @(posedge mclk);
    cs_n <= 1'b1;
  endtask
endmodule

// *** bench/tb_top.sv ***
// self-checking bench for the register access and calibration decoder
`timescale 1ns/1ps
module tb_top
  import rac_pkg::*;
;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic cs_n, sclk, sdi, sdo, cal_start;
  logic [23:0] result_data = 24'h000000;
  logic [23:0] event_set = 24'h000000;
  logic [4:0] result_index;
  logic [5:0] page_sel;
  logic [23:0] event_flags, configuration, control;
  rac_wr_type wr_out;
  rac_cal_type cal_out, cal_seen;
  int num_errors = 0;
  int n_compared = 0;
  int n_cal = 0;
  int n_wr = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h0000C93B;
  logic [31:0] rx;

  always #10 mclk = ~mclk;

  rac_decoder i_rac_decoder (.mclk(mclk), .rst(rst), .cs_n(cs_n),
    .sclk(sclk), .sdi(sdi), .result_data(result_data),
    .event_set(event_set), .sdo(sdo), .result_index(result_index),
    .page_sel(page_sel), .event_flags(event_flags),
    .configuration(configuration), .control(control), .wr_out(wr_out),
    .cal_start(cal_start), .cal_out(cal_out));

  rac_host_model i_rac_host_model (.mclk(mclk), .sdo(sdo), .cs_n(cs_n),
    .sclk(sclk), .sdi(sdi));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // page 0 defaults; everything not listed resets to zero
  function automatic logic [23:0] dflt(input logic [4:0] i);
    case (i)
      5'h00: return 24'h000001;
      5'h02, 5'h04: return 24'h400000;
      5'h05: return 24'h000FA0;
      5'h06: return 24'h800000;
      default: return 24'h000000;
    endcase
  endfunction

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // one frame; nw is how many write strobes it must produce
  task automatic send(input logic [31:0] tx, input logic [23:0] nw);
    int k;
    k = n_wr;
    i_rac_host_model.frame(tx, rx);
    repeat (4) @(posedge mclk);
    check(24'(n_wr - k), nw);
  endtask

  task automatic wr(input logic [4:0] idx, input logic [23:0] v);
    send({1'b0, 1'b1, idx, 1'b0, v}, 24'h000001);
  endtask

  task automatic rd(input logic [4:0] idx, output logic [23:0] d);
    send({1'b0, 1'b0, idx, 1'b0, 24'hFFFFFF}, 24'h000000);
    d = rx[23:0];
  endtask

  task automatic do_reset();
    @(posedge mclk);
    rst <= 1'b1;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
  endtask

  // strobe counters plus the hang guard
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cal_start === 1'b1) begin
      n_cal <= n_cal + 1;
      cal_seen <= cal_out;
    end
    if (wr_out.stb === 1'b1) begin
      n_wr <= n_wr + 1;
    end
    if (cycles == 40000) begin
      num_errors++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [23:0] d, v, cfg;
    logic [4:0] idx;
    logic ok;
    int k;
    do_reset();
    check(configuration, RAC_CONFIGURATION_RST);
    check(24'(page_sel), 24'h000000);
    for (int i = 0; i < 8; i++) begin
      rd(5'(i), d);
      if (i < 7) check(d, dflt(5'(i)));
    end
    // fixed corners first, then random writable page 0 addresses
    cfg = RAC_CONFIGURATION_RST;
    for (int n = 0; n < 14; n++) begin
      seed = xs(seed);
      idx = (n == 0) ? 5'h00 : (n == 1) ? 5'h1C : seed[4:0];
      if (!RAC_P0_WRITABLE[idx]) continue;
      seed = xs(seed);
      v = seed[23:0];
      if (idx == 5'h00) v = v & 24'hFF981F;
      if (idx == 5'h00) cfg = v;
      wr(idx, v);
      check(wr_out.data, v);
      check(24'(wr_out.index), 24'(idx));
      rd(idx, d);
      check(d, v);
      if (idx == 5'h1C) check(control, v);
    end
    check(configuration, cfg);
    // read-only result path
    seed = xs(seed);
    result_data <= seed[23:0];
    rd(5'h07, d);
    check(24'(result_index), 24'h000007);
    check(d, seed[23:0]);
    // paging: page 3, page 1, back to 0
    wr(5'h1F, 24'h000003);
    check(24'(page_sel), 24'h000003);
    v = seed[31:8];
    wr(5'h07, v);
    check(24'(wr_out.page), 24'h000003);
    rd(5'h07, d);
    check(d, v);
    wr(5'h1F, 24'h000001);
    wr(5'h03, ~v);
    rd(5'h03, d);
    check(d, ~v);
    rd(5'h05, d);
    check(d, 24'h000000);
    wr(5'h1F, 24'h000000);
    check(configuration, cfg);
    rd(5'h07, d);
    check(d, seed[23:0]);
    // undefined command bytes change nothing
    send({8'h41, 24'hFFFFFF}, 24'h000000);
    send({8'hA5, 24'hFFFFFF}, 24'h000000);
    check(configuration, cfg);
    check(24'(page_sel), 24'h000000);
    // every calibration field value; references assumed applied
    for (int c = 0; c < 32; c++) begin
      k = n_cal;
      send({3'b110, 5'(c), 24'hFFFFFF}, 24'h000000);
      ok = c[4:3] != 2'b00 && c[1:0] != 2'b00 && c[1:0] != 2'b11;
      check(24'(n_cal - k), 24'(ok));
      if (ok) check(24'(cal_seen), 24'(c));
    end
    // event flags: set by level, cleared by writing ones
    @(posedge mclk);
    event_set <= 24'h00000F;
    @(posedge mclk);
    event_set <= 24'h000000;
    repeat (2) @(posedge mclk);
    check(event_flags, 24'h00000F);
    wr(5'h0F, 24'h000005);
    rd(5'h0F, d);
    check(d, 24'h00000A);
    // second reset in mid-run restores defaults
    wr(5'h1F, 24'h000003);
    do_reset();
    check(configuration, RAC_CONFIGURATION_RST);
    check(24'(page_sel), 24'h000000);
    rd(5'h02, d);
    check(d, RAC_GAIN_RST);
    finish_test();
  end
endmodule
